// >>> core/rtc_pkg.sv
// Purpose: Shared constants and types for the trim, charge and flag logic
// Assumes: 125 MHz system clock; oscillator and bus pins are asynchronous
// Notes:   Register offsets are the byte addresses seen over the two-wire bus
`default_nettype none

package rtc_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // Oscillator counted as stopped after this long without a rising edge
  localparam int OSC_LOSS_NS = 100000;
  localparam int OSC_LOSS_CYC = (OSC_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [6:0] SLAVE_ADDR    = 7'h68;
  localparam logic [7:0] REG_SECONDS   = 8'h00;
  localparam logic [7:0] REG_CTRL      = 8'h07;
  localparam logic [7:0] REG_CHARGE    = 8'h08;
  localparam logic [7:0] REG_FLAG      = 8'h09;
  localparam logic [7:0] REG_ZERO      = 8'h00;
  localparam int         OSC_STOP_BIT  = 7;
  localparam int         OSF_BIT       = 7;
  localparam logic [7:0] CTRL_RESET    = 8'h80;
  localparam logic [7:0] CHARGE_RESET  = 8'h00;
  localparam logic [3:0] CHARGE_UNLOCK = 4'ha;
  localparam logic [1:0] DIODE_NONE    = 2'h1;
  localparam logic [1:0] DIODE_ONE     = 2'h2;
  localparam logic [1:0] RES_OFF       = 2'h0;
  localparam logic [2:0] BIT_LAST      = 3'h7;

  // Divider chain: /256 prescaler, then 128 steps per second
  localparam logic [7:0] PRESCALE_LAST = 8'hff;
  localparam logic [7:0] BLANK_CYCLES  = 8'h80;
  localparam logic [7:0] STEP_NORMAL   = 8'h01;
  localparam logic [7:0] STEP_INSERT   = 8'h02;
  localparam logic [5:0] SEC_LAST      = 6'h3b;
  localparam logic [5:0] MIN_LAST      = 6'h3f;
  localparam int         SQ_BIT        = 5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_WORD = 3'h2,
    ST_WDAT = 3'h3,
    ST_RDAT = 3'h4,
    ST_SACK = 3'h5,
    ST_MACK = 3'h6
  } rtc_state_t;

  typedef struct packed {
    logic       out_level;
    logic       frequency_test_enable;
    logic       trim_pos;
    logic [4:0] trim_magnitude;
  } rtc_ctrl_t;

  typedef struct packed {
    logic [3:0] charge_unlock_pattern;
    logic [1:0] diode_choice;
    logic [1:0] series_resistor_choice;
  } rtc_charge_t;
endpackage

`default_nettype wire

// >>> core/rtc_trim_div.sv
// Purpose: Oscillator divider chain with digital rate trim
// Assumes: tick is one clk pulse per rising edge of the running oscillator
// Notes:   Square output taps the raw count, so trim never reaches it
`default_nettype none

module rtc_trim_div
  import rtc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       clr,
  input  wire logic       tick,
  input  wire logic       trim_pos,
  input  wire logic [4:0] trim_magnitude,
  output logic            sec_tick,
  output logic            sq_out
);
  logic [5:0] raw_r;
  logic [7:0] lo_r;
  logic [6:0] hi_r;
  logic [7:0] blank_r;
  logic [5:0] sec_r;
  logic [5:0] min_r;
  logic       done_r;
  logic       sec_r_tick;

  logic       win;
  logic       carry;
  logic       fix;
  logic [7:0] step;
  logic [7:0] hi_sum;
  logic       wrap;

  // at most 62 of 64 minutes
  assign win    = (sec_r == REG_ZERO[5:0]) && (min_r < {trim_magnitude, 1'b0});
  // correction acts at the /256 stage
  assign carry  = tick && (blank_r == REG_ZERO) && (lo_r == PRESCALE_LAST);
  assign fix    = carry && win && !done_r;
  // insert 256 counts by a double step
  assign step   = (fix && trim_pos) ? STEP_INSERT : STEP_NORMAL;
  assign hi_sum = {1'b0, hi_r} + step;
  assign wrap   = carry && hi_sum[7];

  always_ff @(posedge clk)
  begin
    if (!rst_b || clr)
    begin
      raw_r   <= '0;
      lo_r    <= '0;
      hi_r    <= '0;
      blank_r <= '0;
      sec_r   <= '0;
      min_r   <= '0;
      done_r  <= 1'b0;
      sec_r_tick <= 1'b0;
    end
    else
    begin
      sec_r_tick <= wrap;
      if (tick)
        raw_r <= raw_r + 6'h1;
      // blank 128 counts on slow trim
      if (tick && blank_r != REG_ZERO)
        blank_r <= blank_r - STEP_NORMAL;
      else if (fix && !trim_pos)
        blank_r <= BLANK_CYCLES;
      if (tick && blank_r == REG_ZERO)
        lo_r <= lo_r + STEP_NORMAL;
      if (carry)
        hi_r <= hi_sum[6:0];
      if (fix)
        done_r <= 1'b1;
      // minute count follows the second roll
      if (wrap)
      begin
        done_r <= 1'b0;
        sec_r  <= (sec_r == SEC_LAST) ? 6'h0 : sec_r + 6'h1;
        if (sec_r == SEC_LAST)
          min_r <= (min_r == MIN_LAST) ? 6'h0 : min_r + 6'h1;
      end
    end
  end

  assign sec_tick = sec_r_tick;
  // square tap ahead of any trim
  assign sq_out   = raw_r[SQ_BIT];

  trim_window_a : assert property (@(posedge clk) disable iff (!rst_b)
    $rose(done_r) |-> $past(min_r) < {$past(trim_magnitude), 1'b0})
    else $error("trim applied outside its minute window");

  insert_step_a : assert property (@(posedge clk) disable iff (!rst_b || clr)
    (fix && trim_pos && hi_r < 7'h7e) |=> hi_r == $past(hi_r) + 7'h2)
    else $error("positive trim did not insert 256 counts");
endmodule

`default_nettype wire

// >>> core/rtc_trim_charge_flag.sv
// Purpose: Charge select, halt flag, rate trim and two-wire slave access
// Assumes: scl, sda and oscillator pins arrive asynchronously to clk
// Notes:   Timekeeping counters stay outside; their offsets read as zero, bar seconds bit seven
`default_nettype none

// Overview of operation
// - Charging only with upper select bits exactly 1010.
// - Charge register clears to zero at reset, path off.
// - Diode bits 01 no diode, 10 one diode, others off.
// - Resistor bits 01 small, 10 middle, 11 large, 00 off.
// - Halt flag sets when oscillator goes from running to stopped.
// - Writing oscillator disable stops it and sets the halt flag.
// - Halt flag holds until written zero; writing one does nothing.
// - Flag bits six to zero read zero, writes ignored.
// - Trim adds or removes counts at the divide-by-256 stage.
// - Five-bit magnitude with sign bit five, one speeds up.
// - Sixty-four minute cycle, only first 62 minutes corrected.
// - Slow trim blanks 128 counts, fast trim inserts 256.
// - Corrected minutes equal twice the magnitude.
// - Trim never changes the test square frequency.
// - Any control write restarts the divider chain.
// - Pure bus slave; master owns clock, START and STOP.
// - Works at bus clocks up to 100 and 400 kHz.
// - START is data falling while clock high.
// - STOP is data rising while clock high.
// - Data steady while clock high, one bit per pulse.
// - Any number of bytes between START and STOP.
// - Seconds bit seven stops the oscillator, resets to zero.
// - Test pin toggles at 512 Hz or follows the level bit.
module rtc_trim_charge_flag
  import rtc_pkg::*;
#(
  parameter int OSC_LOSS_LIMIT = OSC_LOSS_CYC
)
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       osc_in,
  output logic            charge_enable,
  output logic            charge_no_diode,
  output logic            charge_one_diode,
  output logic [1:0]      series_resistor_choice,
  output logic            test_square_pin,
  output logic            sec_tick
);
  localparam int PIN_SDA = 0;
  localparam int PIN_SCL = 1;
  localparam int PIN_OSC = 2;

  logic [2:0]  pin_s0_r;
  logic [2:0]  pin_s1_r;
  logic [2:0]  pin_s2_r;
  logic [2:0]  lvl_r;
  logic [2:0]  lvl_nxt;

  rtc_state_t  st_r;
  rtc_state_t  st_nxt;
  rtc_state_t  ret_r;
  rtc_state_t  ret_nxt;
  logic [7:0]  sr_r;
  logic [7:0]  sr_nxt;
  logic [2:0]  cnt_r;
  logic [2:0]  cnt_nxt;
  logic        done_r;
  logic        done_nxt;
  logic [7:0]  ptr_r;
  logic [7:0]  ptr_nxt;
  logic        wr_stb;
  logic        sda_oe_r;
  logic        sda_oe_nxt;

  rtc_ctrl_t   ctrl_r;
  rtc_charge_t charge_r;
  logic        oscillator_disable_r;
  logic        osc_halt_flag_r;
  logic        running_r;
  logic [15:0] wd_r;
  logic        test_pin_r;

  logic        scl_rise;
  logic        scl_fall;
  logic        scl_high;
  logic        start_ev;
  logic        stop_ev;
  logic        osc_rise;
  logic        running;
  logic        run_fall;
  logic        flag_clr;
  logic        div_clr;
  logic        sq_raw;
  logic [7:0]  rd_data;
  logic        unlock_ok;
  logic        diode_ok;

  function automatic logic at(input logic [7:0] ptr, input logic [7:0] addr);
    at = (ptr == addr);
  endfunction

  // Pointer wraps after control and after flag
  function automatic logic [7:0] ptr_inc(input logic [7:0] ptr);
    ptr_inc = (at(ptr, REG_CTRL) || at(ptr, REG_FLAG)) ? REG_ZERO : ptr + 8'h01;
  endfunction

  // Three-flop filter, far faster than 400 kHz bus edges
  assign lvl_nxt  = (pin_s1_r & pin_s2_r) | (lvl_r & (pin_s1_r ^ pin_s2_r));
  assign scl_rise = lvl_nxt[PIN_SCL] && !lvl_r[PIN_SCL];
  assign scl_fall = !lvl_nxt[PIN_SCL] && lvl_r[PIN_SCL];
  assign scl_high = lvl_nxt[PIN_SCL] && lvl_r[PIN_SCL];
  assign start_ev = scl_high && !lvl_nxt[PIN_SDA] && lvl_r[PIN_SDA];
  assign stop_ev  = scl_high && lvl_nxt[PIN_SDA] && !lvl_r[PIN_SDA];
  assign osc_rise = lvl_nxt[PIN_OSC] && !lvl_r[PIN_OSC];

  assign rd_data =
    at(ptr_r, REG_SECONDS) ? {oscillator_disable_r, 7'h00} :
    at(ptr_r, REG_CTRL)    ? ctrl_r :
    at(ptr_r, REG_CHARGE)  ? charge_r :
    at(ptr_r, REG_FLAG)    ? {osc_halt_flag_r, 7'h00} : REG_ZERO;

  always_comb
  begin
    st_nxt   = st_r;
    ret_nxt  = ret_r;
    sr_nxt   = sr_r;
    cnt_nxt  = cnt_r;
    done_nxt = done_r;
    ptr_nxt  = ptr_r;
    wr_stb   = 1'b0;
    // every step is paced by the master's edges
    if (stop_ev)
      st_nxt = ST_IDLE;
    else if (start_ev)
    begin
      // a START from any state restarts framing
      st_nxt   = ST_ADDR;
      cnt_nxt  = '0;
      done_nxt = 1'b0;
    end
    else if (scl_rise)
    begin
      // bits sampled on the clock rise
      case (st_r)
        ST_ADDR, ST_WORD, ST_WDAT:
        begin
          sr_nxt   = {sr_r[6:0], lvl_r[PIN_SDA]};
          cnt_nxt  = cnt_r + 3'h1;
          done_nxt = (cnt_r == BIT_LAST);
        end
        ST_RDAT:
        begin
          cnt_nxt  = cnt_r + 3'h1;
          done_nxt = (cnt_r == BIT_LAST);
        end
        ST_MACK:
          if (lvl_r[PIN_SDA])
            st_nxt = ST_IDLE;
        default:
          st_nxt = st_r;
      endcase
    end
    else if (scl_fall)
    begin
      case (st_r)
        ST_ADDR:
          if (done_r)
          begin
            done_nxt = 1'b0;
            st_nxt   = (sr_r[7:1] == SLAVE_ADDR) ? ST_SACK : ST_IDLE;
            ret_nxt  = sr_r[0] ? ST_RDAT : ST_WORD;
          end
        ST_WORD:
          if (done_r)
          begin
            done_nxt = 1'b0;
            ptr_nxt  = sr_r;
            st_nxt   = ST_SACK;
            ret_nxt  = ST_WDAT;
          end
        ST_WDAT:
          if (done_r)
          begin
            // no byte limit, pointer just wraps
            done_nxt = 1'b0;
            wr_stb   = 1'b1;
            ptr_nxt  = ptr_inc(ptr_r);
            st_nxt   = ST_SACK;
            ret_nxt  = ST_WDAT;
          end
        ST_SACK:
        begin
          st_nxt  = ret_r;
          cnt_nxt = '0;
          sr_nxt  = (ret_r == ST_RDAT) ? rd_data : sr_r;
        end
        ST_RDAT:
          if (done_r)
          begin
            done_nxt = 1'b0;
            ptr_nxt  = ptr_inc(ptr_r);
            st_nxt   = ST_MACK;
          end
          else
            sr_nxt = {sr_r[6:0], 1'b0};
        ST_MACK:
        begin
          st_nxt  = ST_RDAT;
          cnt_nxt = '0;
          sr_nxt  = rd_data;
        end
        default:
          st_nxt = st_r;
      endcase
    end
  end

  // drive changes only follow a clock fall, a START or a STOP
  assign sda_oe_nxt = (st_nxt == ST_SACK) || (st_nxt == ST_RDAT && !sr_nxt[7]);

  always_ff @(posedge clk)
  begin
    pin_s0_r <= {osc_in, scl_in, sda_in};
    pin_s1_r <= pin_s0_r;
    pin_s2_r <= pin_s1_r;
    if (!rst_b)
    begin
      lvl_r    <= 3'h3;
      st_r     <= ST_IDLE;
      ret_r    <= ST_IDLE;
      sr_r     <= '0;
      cnt_r    <= '0;
      done_r   <= 1'b0;
      ptr_r    <= REG_ZERO;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      lvl_r    <= lvl_nxt;
      st_r     <= st_nxt;
      ret_r    <= ret_nxt;
      sr_r     <= sr_nxt;
      cnt_r    <= cnt_nxt;
      done_r   <= done_nxt;
      ptr_r    <= ptr_nxt;
      sda_oe_r <= sda_oe_nxt;
    end
  end

  // Register writes land on the clock fall ending the eighth data bit
  // only a written zero clears the flag
  assign flag_clr = wr_stb && at(ptr_r, REG_FLAG) && !sr_r[OSF_BIT];
  // control or seconds write restarts the chain
  assign div_clr  = wr_stb && (at(ptr_r, REG_CTRL) || at(ptr_r, REG_SECONDS));

  // disable bit counts as a stop
  assign running  = !oscillator_disable_r && (wd_r < 16'(OSC_LOSS_LIMIT));
  // flag is edge triggered on run to stop
  assign run_fall = running_r && !running;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      charge_r             <= CHARGE_RESET;
      ctrl_r               <= CTRL_RESET;
      oscillator_disable_r <= 1'b0;
      // first power-up counts as a stop
      osc_halt_flag_r      <= 1'b1;
      running_r            <= 1'b0;
      wd_r                 <= '0;
      test_pin_r           <= CTRL_RESET[7];
    end
    else
    begin
      running_r <= running;
      wd_r      <= osc_rise ? 16'h0 : (running ? wd_r + 16'h1 : wd_r);
      // 512 Hz square or the level bit
      test_pin_r <= ctrl_r.frequency_test_enable ? sq_raw : ctrl_r.out_level;
      // set wins over a same-cycle clear
      osc_halt_flag_r <= run_fall || (osc_halt_flag_r && !flag_clr);
      if (wr_stb && at(ptr_r, REG_CHARGE))
        charge_r <= sr_r;
      // sign and magnitude stored as written
      if (wr_stb && at(ptr_r, REG_CTRL))
        ctrl_r <= sr_r;
      // seconds bit seven stops the oscillator
      if (wr_stb && at(ptr_r, REG_SECONDS))
        oscillator_disable_r <= sr_r[OSC_STOP_BIT];
    end
  end

  rtc_trim_div u_div (
    .clk            (clk),
    .rst_b          (rst_b),
    .clr            (div_clr),
    .tick           (osc_rise && !oscillator_disable_r),
    .trim_pos       (ctrl_r.trim_pos),
    .trim_magnitude (ctrl_r.trim_magnitude),
    .sec_tick       (sec_tick),
    .sq_out         (sq_raw)
  );

  assign unlock_ok = (charge_r.charge_unlock_pattern == CHARGE_UNLOCK);
  // only 01 and 10 are legal diode codes
  assign diode_ok  = (charge_r.diode_choice == DIODE_NONE) ||
                     (charge_r.diode_choice == DIODE_ONE);
  // any disabling code forces all outputs off
  assign charge_enable          = unlock_ok && diode_ok &&
                                  (charge_r.series_resistor_choice != RES_OFF);
  assign charge_no_diode        = charge_enable && (charge_r.diode_choice == DIODE_NONE);
  assign charge_one_diode       = charge_enable && (charge_r.diode_choice == DIODE_ONE);
  assign series_resistor_choice = charge_enable ? charge_r.series_resistor_choice : RES_OFF;

  assign sda_out         = 1'b0;
  assign sda_oe          = sda_oe_r;
  assign test_square_pin = test_pin_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_halt_write;
    wr_stb && at(ptr_r, REG_SECONDS) && sr_r[OSC_STOP_BIT] && running;
  endsequence

  charge_unlock_a : assert property (charge_enable |-> unlock_ok)
    else $error("charge enabled without unlock pattern");
  charge_reset_a : assert property ($past(!rst_b) |-> !charge_enable && charge_r == '0)
    else $error("charge path not cleared by reset");
  diode_code_a : assert property (charge_enable |-> charge_no_diode != charge_one_diode)
    else $error("diode decode inconsistent");
  res_code_a : assert property (!charge_enable |-> series_resistor_choice == RES_OFF)
    else $error("resistor choice active while charging off");
  halt_set_a : assert property (run_fall |=> osc_halt_flag_r)
    else $error("halt flag missed a stop");
  halt_write_a : assert property (s_halt_write ##1 1'b1 |=> osc_halt_flag_r)
    else $error("disabling oscillator did not set halt flag");
  halt_hold_a : assert property (osc_halt_flag_r && !flag_clr |=> osc_halt_flag_r)
    else $error("halt flag dropped without a zero write");
  flag_low_a : assert property (at(ptr_r, REG_FLAG) |-> rd_data[6:0] == 7'h00)
    else $error("flag low bits not zero");
  sda_steady_a : assert property (scl_high && $past(scl_high) && !$past(start_ev || stop_ev)
    |-> $stable(sda_oe))
    else $error("data drive changed while clock high");
  test_pin_a : assert property (!ctrl_r.frequency_test_enable && $stable(ctrl_r)
    |=> test_square_pin == $past(ctrl_r.out_level))
    else $error("test pin does not follow level bit");
  ack_drive_a : assert property ($rose(st_r == ST_SACK) |=> sda_oe)
    else $error("slave acknowledge not driven");
endmodule

`default_nettype wire

// >>> tb/rtc_bus_master.sv
// Purpose: Two-wire bus master model driving the bus clock and data pins
// Assumes: Pull-up on the data line; the device never stretches the clock
// Notes:   A quarter bit time of 79 clk gives a bus clock just under 400 kHz
`default_nettype none

module rtc_bus_master
#(
  parameter int QTR = 79
)
(
  input  wire logic clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_rel
);
  timeunit 1ns;
  timeprecision 1ps;

  // Master alone owns clock and framing
  initial
  begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic qwait(input int n);
    repeat (n * QTR) @(posedge clk);
  endtask

  task automatic start();
    @(posedge clk);
    sda_rel <= 1'b1;
    qwait(1);
    scl <= 1'b1;
    qwait(1);
    sda_rel <= 1'b0;
    qwait(1);
    scl <= 1'b0;
    qwait(1);
  endtask

  task automatic stop();
    sda_rel <= 1'b0;
    qwait(1);
    scl <= 1'b1;
    qwait(1);
    sda_rel <= 1'b1;
    qwait(2);
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_rel <= b;
    qwait(1);
    scl <= 1'b1;
    qwait(1);
    r = sda_line;
    qwait(1);
    scl <= 1'b0;
    qwait(1);
  endtask

  task automatic byte_io(input logic [7:0] tx, input logic mack,
                         output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mack, ack);
  endtask
endmodule

`default_nettype wire

// >>> tb/rtc_trim_charge_flag_tb.sv
// Purpose: Self-checking bench for charge select, halt flag and test pin
// Assumes: Bus model just under 400 kHz; oscillator stand-in at 64 ns
// Notes:   Minute-scale trim timing is left to the design's own assertions
`default_nettype none

module rtc_trim_charge_flag_tb
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Three oscillator periods of silence count as a stop
  localparam int LOSS = 24;

  logic       clk;
  logic       rst_b;
  logic       osc_in;
  logic       osc_run;
  logic       scl;
  logic       sda_rel;
  wire logic  sda_line;
  logic       sda_oe;
  logic       ch_en;
  logic       ch_nd;
  logic       ch_od;
  logic [1:0] ch_res;
  logic       sq_pin;
  int         num_errors;
  int         check_count;

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Offset keeps oscillator edges away from clk edges
  initial
  begin
    osc_in = 1'b0;
    #5;
    forever
    begin
      #32;
      if (osc_run)
        osc_in = ~osc_in;
    end
  end

  assign sda_line = sda_rel & ~sda_oe;

  rtc_trim_charge_flag #(
    .OSC_LOSS_LIMIT(LOSS)
  ) DUT (
    .clk                    (clk),
    .rst_b                  (rst_b),
    .scl_in                 (scl),
    .sda_in                 (sda_line),
    .sda_out                (),
    .sda_oe                 (sda_oe),
    .osc_in                 (osc_in),
    .charge_enable          (ch_en),
    .charge_no_diode        (ch_nd),
    .charge_one_diode       (ch_od),
    .series_resistor_choice (ch_res),
    .test_square_pin        (sq_pin),
    .sec_tick               ()
  );

  rtc_bus_master u_mst (
    .clk      (clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_rel  (sda_rel)
  );

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] val);
    logic [7:0] rx;
    logic [2:0] ack;
    u_mst.start();
    u_mst.byte_io({SLAVE_ADDR, 1'b0}, 1'b1, rx, ack[2]);
    u_mst.byte_io(ofs, 1'b1, rx, ack[1]);
    u_mst.byte_io(val, 1'b1, rx, ack[0]);
    u_mst.stop();
    chk("write acks", 8'h00, {5'h00, ack});
  endtask

  // Pointer write, repeated start, two bytes read
  task automatic read_two(input logic [7:0] ofs, output logic [15:0] got);
    logic [7:0] rx;
    logic [2:0] ack;
    logic       na;
    u_mst.start();
    u_mst.byte_io({SLAVE_ADDR, 1'b0}, 1'b1, rx, ack[2]);
    u_mst.byte_io(ofs, 1'b1, rx, ack[1]);
    u_mst.start();
    u_mst.byte_io({SLAVE_ADDR, 1'b1}, 1'b1, rx, ack[0]);
    u_mst.byte_io(8'hff, 1'b0, got[15:8], na);
    u_mst.byte_io(8'hff, 1'b1, got[7:0], na);
    u_mst.stop();
    chk("read acks", 8'h00, {5'h00, ack});
  endtask

  function automatic logic [7:0] charge_exp(input logic [7:0] v);
    logic ok;
    ok = (v[7:4] == 4'ha) && (v[3:2] == 2'h1 || v[3:2] == 2'h2) && (v[1:0] != 2'h0);
    return ok ? {4'h1, v[3:2] == 2'h1, v[3:2] == 2'h2, v[1:0]} : 8'h00;
  endfunction

  task automatic t_reset();
    logic [15:0] got;
    chk("charge pins", 8'h00, {3'h0, ch_en, ch_nd, ch_od, ch_res});
    chk("test pin", 8'h01, {7'h00, sq_pin});
    read_two(REG_CHARGE, got);
    chk("charge reg", 8'h00, got[15:8]);
    chk("flag at power-on", 8'h80, got[7:0]);
  endtask

  task automatic t_charge();
    logic [7:0] codes [5] = '{8'ha5, 8'haa, 8'ha7, 8'h5a, 8'hae};
    logic [7:0] pins;
    foreach (codes[i])
    begin
      write_reg(REG_CHARGE, codes[i]);
      pins = {3'h0, ch_en, ch_nd, ch_od, ch_res};
      chk("charge decode", charge_exp(codes[i]), pins);
    end
  endtask

  task automatic t_flag();
    logic [15:0] got;
    write_reg(REG_FLAG, 8'h7f);
    write_reg(REG_FLAG, 8'h80);
    read_two(REG_FLAG, got);
    chk("flag after clear", 8'h00, got[15:8]);
    chk("seconds after wrap", 8'h00, got[7:0]);
    osc_run <= 1'b0;
    repeat (4 * LOSS) @(posedge clk);
    osc_run <= 1'b1;
    read_two(REG_FLAG, got);
    chk("flag after stop", 8'h80, got[15:8]);
  endtask

  // Each half period is 32 oscillator cycles of 8 clk
  task automatic measure(input int halves);
    int   n;
    logic last;
    for (int h = 0; h <= halves; h++)
    begin
      last = sq_pin;
      n = 0;
      while (sq_pin === last && n < 4000)
      begin
        @(posedge clk);
        n++;
      end
      if (n == 4000)
      begin
        num_errors++;
        summarize();
      end
      if (h > 0)
      begin
        check_count++;
        if (n < 254 || n > 258)
        begin
          num_errors++;
          $display("[FAIL] square half period expected 256 seen %0d", n);
        end
      end
    end
  endtask

  // Long enough to span the first blanked stretch
  task automatic t_square();
    write_reg(REG_CTRL, 8'h5f);
    measure(12);
    write_reg(REG_CTRL, 8'h00);
    chk("test pin level", 8'h00, {7'h00, sq_pin});
  endtask

  initial
  begin
    num_errors  = 0;
    check_count = 0;
    rst_b       = 1'b0;
    osc_run     = 1'b1;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_charge();
    t_flag();
    t_square();
    summarize();
  end

  initial
  begin
    repeat (200000) @(posedge clk);
    num_errors++;
    $display("[FAIL] run length expected finish seen timeout");
    summarize();
  end
endmodule

`default_nettype wire
